// [hw/scu_top.sv]
// Overview of operation
// - Low line starts frame after synchronisation
// - Data bits enter shift register LSB first
// - Parity checked against chosen even/odd sense
// - Only first stop bit is checked high
// - Clean frame loads data, sets full flag
// - Finish while full sets overrun, data kept
// - Low stop sets framing error, data copied
// - Parity mismatch sets error, data copied
// - Errors block full flag and further reception
// - Full flag with enable raises receive request
// - Error flags with enable raise error request
// - Extra bit one marks ID, zero data
// - Multiprocessor receiver skips until ID frame
// - Four multiprocessor formats, parity enable ignored
// - Start, data LSB first, extra bit, stops
// - Pending data loads, empty set, sending starts
// - Frame end reloads or sets end flag
// - Sync: drive on falling, capture on rising
// - Sync: LSB to MSB, line holds MSB
// - Sync: eight data bits, no extra bit
// - Sample at eighth of sixteen ticks
// - Mode bits select twelve asynchronous formats
// - Transmit disable empties; receive disable keeps flags
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "scu_defines.svh"

module scu_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input scu_pkg::scu_bus_t bus,
    output logic [7:0] rd_data_r,
    input wire logic rxd_pin,
    output logic txd_r,
    input wire logic sck_in,
    output logic sck_out_r,
    output logic sck_oe_r,
    output scu_pkg::scu_irq_t irq_r
);

    // ------------------------------------------------------------------
    // Registers and pin synchronisers
    // ------------------------------------------------------------------
    scu_pkg::scu_mode_t serial_mode_reg;
    scu_pkg::scu_ctrl_t serial_control_reg;
    scu_pkg::scu_stat_t serial_status_reg;
    logic [7:0] baud_div_r;
    logic [7:0] baud_cnt_r;
    logic [7:0] tx_data_reg;
    logic [7:0] rx_data_reg;
    logic rxd_s1_r, rxd_s2_r, rxd_s3_r;
    logic sck_s1_r, sck_s2_r, sck_s3_r;

    // Two flops before any logic sees a pin; third stage only for edges
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {rxd_s1_r, rxd_s2_r, rxd_s3_r} <= 3'h7;
            {sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h7;
        end else begin
            {rxd_s1_r, rxd_s2_r, rxd_s3_r} <= {rxd_pin, rxd_s1_r, rxd_s2_r};
            {sck_s1_r, sck_s2_r, sck_s3_r} <= {sck_in, sck_s1_r, sck_s2_r};
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire wr_mode = bus.wr && bus.addr == `SCU_A_MODE;
    wire wr_baud = bus.wr && bus.addr == `SCU_A_BAUD;
    wire wr_ctrl = bus.wr && bus.addr == `SCU_A_CTRL;
    wire wr_txd = bus.wr && bus.addr == `SCU_A_TXD;
    wire wr_stat = bus.wr && bus.addr == `SCU_A_STAT;
    wire [7:0] rd_mux =
        bus.addr == `SCU_A_MODE ? {1'b0, serial_mode_reg} :
        bus.addr == `SCU_A_BAUD ? baud_div_r :
        bus.addr == `SCU_A_CTRL ? {1'b0, serial_control_reg} :
        bus.addr == `SCU_A_TXD ? tx_data_reg :
        bus.addr == `SCU_A_STAT ? {1'b0, serial_status_reg} :
        bus.addr == `SCU_A_RXD ? rx_data_reg : 8'h00;
    // Status flags are cleared by writing 0; writing 1 leaves them
    wire clr_end = wr_stat && !bus.wdata[`SCU_ST_TX_END_FLAG];
    wire clr_perr = wr_stat && !bus.wdata[`SCU_ST_PERR];
    wire clr_ferr = wr_stat && !bus.wdata[`SCU_ST_FERR];
    wire clr_ovr = wr_stat && !bus.wdata[`SCU_ST_OVR];
    wire clr_full = wr_stat && !bus.wdata[`SCU_ST_FULL];
    wire clr_empty = wr_txd || (wr_stat && !bus.wdata[`SCU_ST_EMPTY]);

    // ------------------------------------------------------------------
    // Clock source: 16x tick, serial clock edges
    // ------------------------------------------------------------------
    scu_pkg::scu_tx_st_t tx_st_r;
    scu_pkg::scu_rx_st_t rx_st_r;
    logic [3:0] sph_r;
    logic sck_hold;
    wire err_any = serial_status_reg.overrun_flag |
                   serial_status_reg.framing_err_flag |
                   serial_status_reg.parity_err_flag;
    wire sck_rise = sck_s2_r && !sck_s3_r;
    wire sck_fall = !sck_s2_r && sck_s3_r;
    wire int_tick = baud_cnt_r == 8'h00;
    wire tick = serial_mode_reg.ext_clk ? sck_rise : int_tick;
    wire tx_pending = serial_control_reg.tx_enable_bit &&
                      !serial_status_reg.tx_empty_flag;
    // Internal sync clock runs while there is work; stops on error
    wire sync_run = serial_mode_reg.sync_mode && !err_any &&
        (tx_st_r != scu_pkg::SCU_TX_IDLE || tx_pending ||
         serial_control_reg.rx_enable_bit);
    wire ser_fall = serial_mode_reg.ext_clk ? sck_fall :
                    (sync_run && int_tick && sph_r == 4'h0);
    wire ser_rise = serial_mode_reg.ext_clk ? sck_rise :
                    (sync_run && int_tick && sph_r == `SCU_SYNC_RISE_PH);

    // Baud divider and sync clock phase; clock idles high
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            baud_cnt_r <= 8'h00;
            sph_r <= 4'h0;
            sck_out_r <= 1'b1;
            sck_oe_r <= 1'b0;
        end else begin
            baud_cnt_r <= int_tick ? baud_div_r : baud_cnt_r - 8'h01;
            sph_r <= !sync_run ? 4'h0 : sph_r + {3'h0, int_tick};
            sck_out_r <= !(sync_run && !sck_hold &&
                           sph_r < `SCU_SYNC_RISE_PH);
            sck_oe_r <= serial_mode_reg.sync_mode &&
                        !serial_mode_reg.ext_clk;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    logic [11:0] tsh_r;
    logic [3:0] tcnt_r;
    logic [3:0] tph_r;
    logic [11:0] frame;
    logic [3:0] flen;

    // Frame image: start, data LSB first, extra bit, stop ones
    always_comb begin
        logic [3:0] dl;
        logic extra, pbit;
        dl = serial_mode_reg.char_length_bit ? 4'h7 : 4'h8;
        extra = serial_mode_reg.parity_enable_bit |
                serial_mode_reg.multiproc_mode_bit;
        pbit = serial_mode_reg.multiproc_mode_bit ?
               serial_control_reg.mp_bit_tx_value :
               (^(tx_data_reg & {~serial_mode_reg.char_length_bit,
               7'h7F})) ^ serial_mode_reg.parity_odd;
        frame = 12'hFFF;
        frame[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < dl) begin
                frame[i + 1] = tx_data_reg[i];
            end
        end
        if (extra) begin
            frame[dl + 4'h1] = pbit;
        end
        flen = 4'h2 + dl + {3'h0, extra} +
               {3'h0, serial_mode_reg.two_stop};
        if (serial_mode_reg.sync_mode) begin
            frame = {4'hF, tx_data_reg};
            flen = `SCU_SYNC_BITS;
        end
    end

    wire tx_bit_end = serial_mode_reg.sync_mode ? ser_fall :
                      (tick && tph_r == `SCU_LAST_PH);
    wire tx_last = tx_st_r == scu_pkg::SCU_TX_SEND && tx_bit_end &&
                   tcnt_r == 4'h0;
    wire tx_start_ok = serial_mode_reg.sync_mode ? ser_fall : 1'b1;
    wire tx_load = tx_pending && !err_any &&
        ((tx_st_r == scu_pkg::SCU_TX_IDLE && tx_start_ok) || tx_last);
    wire tx_done = tx_last && !tx_load;
    // With receive off, the fall that ends a frame stays off the pin, else a ninth pulse
    assign sck_hold = tx_done && !serial_control_reg.rx_enable_bit;

    // Shift out one bit per period; in sync mode the line keeps MSB
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_st_r <= scu_pkg::SCU_TX_IDLE;
            tsh_r <= 12'hFFF;
            tcnt_r <= 4'h0;
            tph_r <= 4'h0;
            txd_r <= 1'b1;
        end else if (!serial_control_reg.tx_enable_bit) begin
            tx_st_r <= scu_pkg::SCU_TX_IDLE;
            tsh_r <= 12'hFFF;
            tcnt_r <= 4'h0;
            tph_r <= 4'h0;
            txd_r <= 1'b1;
        end else if (tx_load) begin
            tx_st_r <= scu_pkg::SCU_TX_SEND;
            txd_r <= frame[0];
            tsh_r <= {1'b1, frame[11:1]};
            tcnt_r <= flen - 4'h1;
            tph_r <= 4'h0;
        end else if (tx_done) begin
            tx_st_r <= scu_pkg::SCU_TX_IDLE;
        end else if (tx_st_r == scu_pkg::SCU_TX_SEND) begin
            tph_r <= tph_r + {3'h0, tick};
            if (tx_bit_end) begin
                txd_r <= tsh_r[0];
                tsh_r <= {1'b1, tsh_r[11:1]};
                tcnt_r <= tcnt_r - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    logic [9:0] rf_r;
    logic [3:0] ridx_r;
    logic [3:0] rph_r;
    wire [3:0] rx_dl = serial_mode_reg.sync_mode ? 4'h8 :
                       (serial_mode_reg.char_length_bit ? 4'h7 : 4'h8);
    wire rx_extra = !serial_mode_reg.sync_mode &&
        (serial_mode_reg.parity_enable_bit |
         serial_mode_reg.multiproc_mode_bit);
    wire [3:0] rx_last_idx = serial_mode_reg.sync_mode ?
                             `SCU_SYNC_LAST : rx_dl + {3'h0, rx_extra};
    wire rx_may = serial_control_reg.rx_enable_bit && !err_any;
    wire rx_fall_seen = rxd_s3_r && !rxd_s2_r;
    wire rx_capture = rx_st_r == scu_pkg::SCU_RX_DATA &&
        (serial_mode_reg.sync_mode ? ser_rise :
         (tick && rph_r == `SCU_LAST_PH));
    wire rx_fin = rx_capture && ridx_r == rx_last_idx;

    // Frame as it stands with the bit being captured now
    logic [9:0] rf_new;
    always_comb begin
        rf_new = rf_r;
        rf_new[ridx_r] = rxd_s2_r;
    end

    wire [7:0] fin_data = rx_dl == 4'h7 ? {1'b0, rf_new[6:0]} :
                          rf_new[7:0];
    wire fin_xbit = rf_new[rx_dl];
    wire fin_stop = serial_mode_reg.sync_mode || rxd_s2_r;
    wire fin_perr = !serial_mode_reg.sync_mode &&
        serial_mode_reg.parity_enable_bit &&
        !serial_mode_reg.multiproc_mode_bit &&
        ((^fin_data) ^ fin_xbit) != serial_mode_reg.parity_odd;
    wire fin_skip = !serial_mode_reg.sync_mode &&
        serial_mode_reg.multiproc_mode_bit &&
        serial_control_reg.id_wait && !fin_xbit;
    wire fin_use = rx_fin && !fin_skip;
    wire set_ovr = fin_use && serial_status_reg.rx_full_flag;
    wire set_ferr = fin_use && !set_ovr && !fin_stop;
    wire set_perr = fin_use && !set_ovr && fin_perr;
    wire set_full = fin_use && !set_ovr && !set_ferr && !set_perr;
    wire rdr_load = fin_use && !set_ovr;
    wire id_seen = fin_use && !serial_mode_reg.sync_mode &&
                   serial_mode_reg.multiproc_mode_bit && fin_xbit;

    // Start detect, centre check, then one sample per bit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_st_r <= scu_pkg::SCU_RX_IDLE;
            rf_r <= 10'h000;
            ridx_r <= 4'h0;
            rph_r <= 4'h0;
        end else begin
            unique case (rx_st_r)
                scu_pkg::SCU_RX_IDLE: begin
                    rph_r <= 4'h0;
                    ridx_r <= 4'h0;
                    if (rx_may && serial_mode_reg.sync_mode) begin
                        rx_st_r <= scu_pkg::SCU_RX_DATA;
                    end else if (rx_may && rx_fall_seen) begin
                        rx_st_r <= scu_pkg::SCU_RX_START;
                    end
                end
                scu_pkg::SCU_RX_START: begin
                    rph_r <= rph_r + {3'h0, tick};
                    if (!serial_control_reg.rx_enable_bit) begin
                        rx_st_r <= scu_pkg::SCU_RX_IDLE;
                    end else if (tick && rph_r == `SCU_SAMPLE_PH) begin
                        // A high centre means a glitch, not a start
                        rx_st_r <= rxd_s2_r ? scu_pkg::SCU_RX_IDLE :
                                   scu_pkg::SCU_RX_DATA;
                        rph_r <= 4'h0;
                    end
                end
                scu_pkg::SCU_RX_DATA: begin
                    rph_r <= rph_r + {3'h0, tick};
                    if (!serial_control_reg.rx_enable_bit) begin
                        rx_st_r <= scu_pkg::SCU_RX_IDLE;
                    end else if (rx_fin) begin
                        rx_st_r <= scu_pkg::SCU_RX_IDLE;
                    end else if (rx_capture) begin
                        rf_r <= rf_new;
                        ridx_r <= ridx_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Software registers; a hardware set wins over a same-cycle clear
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            serial_mode_reg <= `SCU_MODE_RST;
            serial_control_reg <= `SCU_CTRL_RST;
            serial_status_reg <= `SCU_STAT_RST;
            baud_div_r <= `SCU_BAUD_RST;
            tx_data_reg <= 8'h00;
            rx_data_reg <= 8'h00;
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= bus.rd ? rd_mux : 8'h00;
            if (wr_mode) serial_mode_reg <= bus.wdata[6:0];
            if (wr_baud) baud_div_r <= bus.wdata;
            if (wr_txd) tx_data_reg <= bus.wdata;
            if (rdr_load) rx_data_reg <= fin_data;
            if (wr_ctrl) begin
                serial_control_reg <= bus.wdata[6:0];
            end else if (id_seen) begin
                serial_control_reg.id_wait <= 1'b0;
            end
            serial_status_reg.tx_empty_flag <= tx_load ||
                !serial_control_reg.tx_enable_bit ||
                (serial_status_reg.tx_empty_flag && !clr_empty);
            serial_status_reg.tx_end_flag <= tx_done ||
                (serial_status_reg.tx_end_flag && !clr_end &&
                 !tx_load);
            serial_status_reg.rx_full_flag <= set_full ||
                (serial_status_reg.rx_full_flag && !clr_full);
            serial_status_reg.overrun_flag <= set_ovr ||
                (serial_status_reg.overrun_flag && !clr_ovr);
            serial_status_reg.framing_err_flag <= set_ferr ||
                (serial_status_reg.framing_err_flag && !clr_ferr);
            serial_status_reg.parity_err_flag <= set_perr ||
                (serial_status_reg.parity_err_flag && !clr_perr);
            if (rdr_load) serial_status_reg.mp_bit_rx_value <= fin_xbit;
        end
    end

    // Level requests, each gated by its enable
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_r <= '0;
        end else begin
            irq_r.rx_full_irq <= serial_control_reg.rx_irq_enable &&
                serial_status_reg.rx_full_flag;
            irq_r.rx_error_irq <= serial_control_reg.rx_irq_enable &&
                err_any;
            irq_r.tx_empty_irq <= serial_control_reg.tx_irq_enable &&
                serial_status_reg.tx_empty_flag;
            irq_r.tx_end_irq <= serial_control_reg.tx_end_irq_enable &&
                serial_status_reg.tx_end_flag;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    rx_clean_a: assert property (set_full |=>
        serial_status_reg.rx_full_flag && rx_data_reg == $past(fin_data))
        else $error("clean frame not delivered");
    rx_ovr_a: assert property (set_ovr |=>
        serial_status_reg.overrun_flag && $stable(rx_data_reg))
        else $error("overrun handling wrong");
    rx_frame_a: assert property (fin_use && !fin_stop &&
        !serial_status_reg.rx_full_flag |=> serial_status_reg.framing_err_flag
        && !serial_status_reg.rx_full_flag
        && rx_data_reg == $past(fin_data))
        else $error("framing error handling wrong");
    rx_parity_a: assert property (set_perr |=>
        serial_status_reg.parity_err_flag && rx_data_reg == $past(fin_data))
        else $error("parity error handling wrong");
    rx_block_a: assert property (err_any |->
        rx_st_r == scu_pkg::SCU_RX_IDLE && !set_full)
        else $error("receiver active with error");
    irq_full_a: assert property ($rose(serial_status_reg.rx_full_flag) &&
        serial_control_reg.rx_irq_enable && !wr_ctrl |=> irq_r.rx_full_irq)
        else $error("receive request missing");
    irq_err_a: assert property ($rose(err_any) &&
        serial_control_reg.rx_irq_enable && !wr_ctrl |=> irq_r.rx_error_irq)
        else $error("error request missing");
    mp_skip_a: assert property (rx_fin && fin_skip && !wr_stat |=>
        $stable(rx_data_reg) && $stable(serial_status_reg[5:2]) &&
        $stable(serial_status_reg.mp_bit_rx_value))
        else $error("skipped frame changed state");
    tx_start_a: assert property (tx_load &&
        !serial_mode_reg.sync_mode |=> !txd_r &&
        serial_status_reg.tx_empty_flag ##1 !txd_r)
        else $error("start bit or empty flag wrong");
    tx_edge_a: assert property (serial_mode_reg.sync_mode &&
        tx_st_r == scu_pkg::SCU_TX_SEND && $changed(txd_r) &&
        $stable(serial_mode_reg) |-> $past(ser_fall))
        else $error("sync data moved off falling edge");
    tx_off_a: assert property (!serial_control_reg.tx_enable_bit |=>
        serial_status_reg.tx_empty_flag && tx_st_r == scu_pkg::SCU_TX_IDLE)
        else $error("transmit disable not honoured");

    rx_ok_c: cover property (set_full);
    rx_ovr_c: cover property (set_ovr);
    tx_end_c: cover property (tx_done);
    mp_id_c: cover property (id_seen);

endmodule

// [hw/scu_defines.svh]
`ifndef SCU_DEFINES_SVH
`define SCU_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------------
`define SCU_A_MODE 3'h0
`define SCU_A_BAUD 3'h1
`define SCU_A_CTRL 3'h2
`define SCU_A_TXD 3'h3
`define SCU_A_STAT 3'h4
`define SCU_A_RXD 3'h5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SCU_MODE_RST 7'h00
`define SCU_CTRL_RST 7'h00
`define SCU_BAUD_RST 8'h0F
`define SCU_STAT_RST 7'h60

// ----------------------------------------------------------------------
// Status field positions (write 0 clears)
// ----------------------------------------------------------------------
`define SCU_ST_TX_END_FLAG 1
`define SCU_ST_PERR 2
`define SCU_ST_FERR 3
`define SCU_ST_OVR 4
`define SCU_ST_FULL 5
`define SCU_ST_EMPTY 6

// ----------------------------------------------------------------------
// Bit timing in 16x sample ticks
// ----------------------------------------------------------------------
`define SCU_SAMPLE_PH 4'h7
`define SCU_LAST_PH 4'hF
`define SCU_SYNC_RISE_PH 4'h8
`define SCU_SYNC_BITS 4'h8
`define SCU_SYNC_LAST 4'h7

`endif

// [hw/scu_pkg.sv]
package scu_pkg;

    // Mode register layout, bit 0 is the stop length
    typedef struct packed {
        logic ext_clk;
        logic sync_mode;
        logic char_length_bit;
        logic parity_enable_bit;
        logic parity_odd;
        logic multiproc_mode_bit;
        logic two_stop;
    } scu_mode_t;

    // Control register layout
    typedef struct packed {
        logic tx_irq_enable;
        logic rx_irq_enable;
        logic tx_enable_bit;
        logic rx_enable_bit;
        logic tx_end_irq_enable;
        logic mp_bit_tx_value;
        logic id_wait;
    } scu_ctrl_t;

    // Status register layout
    typedef struct packed {
        logic tx_empty_flag;
        logic rx_full_flag;
        logic overrun_flag;
        logic framing_err_flag;
        logic parity_err_flag;
        logic tx_end_flag;
        logic mp_bit_rx_value;
    } scu_stat_t;

    // One register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } scu_bus_t;

    // Interrupt request lines
    typedef struct packed {
        logic rx_error_irq;
        logic rx_full_irq;
        logic tx_empty_irq;
        logic tx_end_irq;
    } scu_irq_t;

    typedef enum logic [1:0] {
        SCU_TX_IDLE = 2'b00,
        SCU_TX_SEND = 2'b01
    } scu_tx_st_t;

    typedef enum logic [1:0] {
        SCU_RX_IDLE = 2'b00,
        SCU_RX_START = 2'b01,
        SCU_RX_DATA = 2'b11
    } scu_rx_st_t;

endpackage

// [tb/scu_remote.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Remote station on the shared line, 16 clocks a bit at divisor 0
// ----------------------------------------------------------------------
module scu_remote (
    input wire logic sys_clk,
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;

    // Start, n bits LSB first, one stop; idle high after, as a pull-up would
    task automatic send(input logic [8:0] d, input int n, input logic stp);
        for (int i = -1; i <= n; i++) begin
            rxd <= (i < 0) ? 1'b0 : (i == n) ? stp : d[i];
            repeat (16) @(posedge sys_clk);
        end
        rxd <= 1'b1;
        repeat (32) @(posedge sys_clk);
    endtask

    // Bounded hunt for a start bit, then mid-bit sampling
    task automatic rcv(output logic [7:0] d, output logic ok);
        int k;
        k = 0;
        d = 8'h00;
        while (txd !== 1'b0 && k < 4000) begin
            @(posedge sys_clk);
            k++;
        end
        repeat (8) @(posedge sys_clk);
        ok = (txd === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge sys_clk);
            d[i] = txd;
        end
        repeat (16) @(posedge sys_clk);
        ok = ok && (txd === 1'b1);
    endtask
endmodule

// [tb/scu_top_tb.sv]
`timescale 1ns/1ps
`include "scu_defines.svh"
module scu_top_tb;
    logic sys_clk, nrst, rxd, txd_r, sck_out_r, sck_oe_r, ok;
    logic [7:0] rd_data_r, v;
    scu_pkg::scu_bus_t bus;
    scu_pkg::scu_irq_t irq_r;
    int n_fail, samples_checked;

    scu_top scu_top_inst (.sys_clk(sys_clk), .nrst(nrst), .bus(bus),
        .rd_data_r(rd_data_r), .rxd_pin(rxd), .txd_r(txd_r),
        .sck_in(1'b1), .sck_out_r(sck_out_r), .sck_oe_r(sck_oe_r),
        .irq_r(irq_r));
    scu_remote scu_remote_inst (.sys_clk(sys_clk), .txd(txd_r), .rxd(rxd));

    // ------------------------------------------------------------------
    // Bus cycles and compares
    // ------------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [2:0] a, input logic [7:0] m,
                       input logic [7:0] e);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        chk_bit((rd_data_r & m) === e);
    endtask
    task automatic chk_bit(input logic good);
        samples_checked++;
        if (good !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: compare mismatch", $time);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Clean frame, a second after clearing full, then a third while still full
    task automatic t_rx;
        scu_remote_inst.send({1'b0, 8'hA5}, 8, 1'b1);
        rdc(`SCU_A_STAT, 8'h3C, 8'h20);
        chk_bit(irq_r.rx_full_irq === 1'b1);
        rdc(`SCU_A_RXD, 8'hFF, 8'hA5);
        wr(`SCU_A_STAT, 8'h5F);
        scu_remote_inst.send({1'b0, 8'h96}, 8, 1'b1);
        rdc(`SCU_A_STAT, 8'h30, 8'h20);
        rdc(`SCU_A_RXD, 8'hFF, 8'h96);
        scu_remote_inst.send({1'b0, 8'h5A}, 8, 1'b1);
        rdc(`SCU_A_STAT, 8'h10, 8'h10);
        chk_bit(irq_r.rx_error_irq === 1'b1);
        rdc(`SCU_A_RXD, 8'hFF, 8'h96);
        wr(`SCU_A_STAT, 8'h43);
    endtask

    // Low stop bit; a later clean frame must be held off by the error
    task automatic t_frame;
        scu_remote_inst.send({1'b0, 8'h3C}, 8, 1'b0);
        rdc(`SCU_A_STAT, 8'h1C, 8'h08);
        rdc(`SCU_A_RXD, 8'hFF, 8'h3C);
        scu_remote_inst.send({1'b0, 8'h11}, 8, 1'b1);
        rdc(`SCU_A_STAT, 8'h20, 8'h00);
        wr(`SCU_A_STAT, 8'h43);
    endtask

    // Even parity: 8'h07 needs a one in the parity slot
    task automatic t_parity;
        wr(`SCU_A_MODE, 8'h08);
        scu_remote_inst.send({1'b0, 8'h07}, 9, 1'b1);
        rdc(`SCU_A_STAT, 8'h1C, 8'h04);
        rdc(`SCU_A_RXD, 8'hFF, 8'h07);
        wr(`SCU_A_STAT, 8'h43);
        scu_remote_inst.send({1'b1, 8'h07}, 9, 1'b1);
        rdc(`SCU_A_STAT, 8'h3C, 8'h20);
        wr(`SCU_A_STAT, 8'h43);
    endtask

    // Waiting for an ID; parity enable set too and must be ignored
    task automatic t_mp;
        wr(`SCU_A_MODE, 8'h0A);
        wr(`SCU_A_CTRL, 8'h39);
        scu_remote_inst.send({1'b0, 8'h66}, 9, 1'b1);
        rdc(`SCU_A_STAT, 8'h3C, 8'h00);
        chk_bit(irq_r.rx_full_irq === 1'b0);
        scu_remote_inst.send({1'b1, 8'h42}, 9, 1'b1);
        rdc(`SCU_A_STAT, 8'h3C, 8'h20);
        rdc(`SCU_A_RXD, 8'hFF, 8'h42);
        wr(`SCU_A_STAT, 8'h43);
    endtask

    // One frame out with nothing queued behind it
    task automatic t_tx;
        wr(`SCU_A_MODE, 8'h00);
        wr(`SCU_A_CTRL, 8'h7C);
        wr(`SCU_A_TXD, 8'hC3);
        scu_remote_inst.rcv(v, ok);
        chk_bit(ok === 1'b1);
        chk_bit(v === 8'hC3);
        if (ok !== 1'b1)
            end_sim();
        repeat (24) @(posedge sys_clk);
        rdc(`SCU_A_STAT, 8'h42, 8'h42);
        chk_bit(txd_r === 1'b1);
        chk_bit(irq_r.tx_end_irq === 1'b1);
        chk_bit(irq_r.tx_empty_irq === 1'b1);
    endtask

    // Internal clock sync send: eight pulses, data read on each rise
    task automatic t_sync;
        int k;
        k = 0;
        v = 8'h00;
        wr(`SCU_A_CTRL, 8'h00);
        wr(`SCU_A_MODE, 8'h20);
        wr(`SCU_A_CTRL, 8'h10);
        wr(`SCU_A_TXD, 8'h69);
        for (int i = 0; i < 8; i++) begin
            while (sck_out_r !== 1'b0 && k < 900) begin
                @(posedge sys_clk);
                k++;
            end
            while (sck_out_r !== 1'b1 && k < 900) begin
                @(posedge sys_clk);
                k++;
            end
            v[i] = txd_r;
        end
        chk_bit(k < 900);
        chk_bit(v === 8'h69);
        chk_bit(sck_oe_r === 1'b1);
        // Clock must stand high and the line keep the MSB after the frame
        k = 0;
        repeat (40) begin
            @(posedge sys_clk);
            k += (sck_out_r !== 1'b1 || txd_r !== 1'b0);
        end
        chk_bit(k == 0);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        n_fail = 0;
        samples_checked = 0;
        nrst = 1'b0;
        bus = '0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rdc(`SCU_A_STAT, 8'h7E, 8'h60);
        wr(`SCU_A_STAT, 8'h5F);
        wr(`SCU_A_BAUD, 8'h00);
        wr(`SCU_A_MODE, 8'h00);
        wr(`SCU_A_CTRL, 8'h38);
        t_rx();
        t_frame();
        t_parity();
        t_mp();
        t_tx();
        t_sync();
        end_sim();
    end
endmodule
